// ---- design/csg_pkg.sv ----
// Constants, layouts and types for the command state gate and its configuration memory.
// Assumes one 25 MHz clock and a synchronous active-high reset.
package csg_pkg;

    // ----------------
    // Configuration memory offsets (register index, byte address = 4 x index)
    // ----------------
    localparam logic [7:0] OFS_ENTRY_CHAR  = 8'h03;
    localparam logic [7:0] OFS_PRE_PTR_HI  = 8'h3c;
    localparam logic [7:0] OFS_PRE_PTR_LO  = 8'h3d;
    localparam logic [7:0] OFS_POST_PTR_HI = 8'h3e;
    localparam logic [7:0] OFS_POST_PTR_LO = 8'h3f;
    localparam logic [2:0][7:0] OFS_PRESET = {8'h46, 8'h43, 8'h40};
    localparam logic [2:0][7:0] OFS_STR_HI = {8'h47, 8'h44, 8'h41};
    localparam logic [2:0][7:0] OFS_STR_LO = {8'h48, 8'h45, 8'h42};
    localparam logic [7:0] OFS_CLICK_RPT   = 8'h80;
    localparam logic [7:0] OFS_RA_DELAY    = 8'h81;
    localparam logic [7:0] OFS_RA_INTERVAL = 8'h82;
    localparam logic [7:0] OFS_RB_DELAY    = 8'h83;
    localparam logic [7:0] OFS_RB_INTERVAL = 8'h84;
    localparam logic [7:0] OFS_BASE_LAYER  = 8'h87;
    localparam logic [7:0] OFS_LAYER_HI    = 8'h88;
    localparam logic [7:0] OFS_LAYER_LO    = 8'h89;
    localparam logic [7:0] OFS_PAR_DIR     = 8'h8c;
    localparam logic [3:0][7:0] OFS_SER_FMT  = {8'h97, 8'h94, 8'h91, 8'h8e};
    localparam logic [3:0][7:0] OFS_SER_FLOW = {8'h98, 8'h95, 8'h92, 8'h8f};
    localparam logic [7:0] OFS_DISP_PRIV   = 8'h9a;
    localparam logic [7:0] OFS_STATUS      = 8'hf0;
    localparam logic [2:0][7:0] OFS_COUNT  = {8'hf3, 8'hf2, 8'hf1};

    // ----------------
    // Reset values and fixed characters
    // ----------------
    localparam logic [7:0] RST_ENTRY_CHAR  = 8'h02;
    localparam logic [7:0] RST_POST_LO     = 8'h32;
    localparam logic [7:0] RST_PRESET      = 8'h01;
    localparam logic [7:0] RST_CLICK_RPT   = 8'h41;
    localparam logic [7:0] RST_RA_DELAY    = 8'h25;
    localparam logic [7:0] RST_RA_INTERVAL = 8'h19;
    localparam logic [7:0] RST_RB_DELAY    = 8'h19;
    localparam logic [7:0] RST_RB_INTERVAL = 8'h05;
    localparam logic [7:0] RST_BASE_LAYER  = 8'h80;
    localparam logic [7:0] RST_BASE_LAYER2 = 8'h81;
    localparam logic [7:0] RST_PAR_DIR     = 8'h00;
    localparam logic [7:0] RST_SER_FMT     = 8'h42;
    localparam logic [7:0] RST_SER_FLOW    = 8'h0c;
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [7:0] EXIT_CHAR       = 8'h03;

    // ----------------
    // Status layout and timing
    // ----------------
    localparam int STAT_CMD_BIT      = 0;
    localparam int STAT_PEND_LSB     = 1;
    localparam int FIFO_DEPTH        = 8;
    localparam int REPEAT_UNIT_US    = 20000;
    localparam int CLK_FREQ_MHZ      = 25;
    localparam int REPEAT_UNIT_CYCLES = REPEAT_UNIT_US * CLK_FREQ_MHZ;
    localparam int TICK_W            = 20;

    // ----------------
    // Types
    // ----------------
    typedef struct packed {
        logic       cmd;
        logic [7:0] ch;
    } csg_char_t;

    typedef struct packed {
        logic [7:0]      entry_char;
        logic [15:0]     token_pre_ptr;
        logic [15:0]     token_post_ptr;
        logic [7:0]      click_repeat;
        logic [7:0]      base_layer;
        logic [15:0]     first_layer_ptr;
        logic            first_layer_present;
        logic [7:0]      parallel_dir;
        logic [3:0][7:0] serial_fmt;
        logic [3:0][7:0] serial_flow;
        logic [7:0]      display_private;
    } csg_cfg_t;

    // ----------------
    // Decode helpers
    // ----------------
    function automatic logic csg_is_cfg(input logic [7:0] idx);
        logic hit;
        hit = (idx == OFS_ENTRY_CHAR) || (idx >= OFS_PRE_PTR_HI && idx <= OFS_STR_LO[2]) ||
              (idx >= OFS_CLICK_RPT && idx <= OFS_RB_INTERVAL) ||
              (idx >= OFS_BASE_LAYER && idx <= OFS_LAYER_LO) || (idx == OFS_PAR_DIR) ||
              (idx == OFS_DISP_PRIV);
        for (int i = 0; i < 4; i++) begin
            hit = hit || (idx == OFS_SER_FMT[i]) || (idx == OFS_SER_FLOW[i]);
        end
        return hit;
    endfunction : csg_is_cfg

    function automatic logic [7:0] csg_default(input logic [7:0] idx, input logic variant2);
        logic [7:0] v;
        v = RST_ZERO;
        if (idx == OFS_ENTRY_CHAR) v = RST_ENTRY_CHAR;
        else if (idx == OFS_POST_PTR_LO) v = RST_POST_LO;
        else if (idx == OFS_PRESET[0] || idx == OFS_PRESET[1] || idx == OFS_PRESET[2])
            v = RST_PRESET;
        else if (idx == OFS_CLICK_RPT) v = RST_CLICK_RPT;
        else if (idx == OFS_RA_DELAY) v = RST_RA_DELAY;
        else if (idx == OFS_RA_INTERVAL) v = RST_RA_INTERVAL;
        else if (idx == OFS_RB_DELAY) v = RST_RB_DELAY;
        else if (idx == OFS_RB_INTERVAL) v = RST_RB_INTERVAL;
        else if (idx == OFS_BASE_LAYER) v = variant2 ? RST_BASE_LAYER2 : RST_BASE_LAYER;
        else if (idx == OFS_PAR_DIR) v = RST_PAR_DIR;
        for (int i = 0; i < 4; i++) begin
            if (idx == OFS_SER_FMT[i]) v = RST_SER_FMT;
            if (idx == OFS_SER_FLOW[i]) v = RST_SER_FLOW;
        end
        return v;
    endfunction : csg_default

endpackage : csg_pkg

// ---- design/csg_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module csg_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
    } fifo_state_t;

    fifo_state_t state_reg;
    fifo_state_t state_next;
    logic        push;
    logic        pop;

    // ----------------
    // Flags
    // ----------------
    assign in_ready  = (state_reg.count != (AW+1)'(DEPTH));
    assign out_valid = (state_reg.count != '0);
    assign out_data  = state_reg.mem[state_reg.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ----------------
    // Pointers and storage
    // ----------------
    always_comb begin
        state_next = state_reg;
        if (push) begin
            state_next.mem[state_reg.wr_ptr] = in_data;
            state_next.wr_ptr = (state_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : state_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            state_next.rd_ptr = (state_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : state_reg.rd_ptr + 1'b1;
        end
        if (push && !pop) state_next.count = state_reg.count + 1'b1;
        else if (pop && !push) state_next.count = state_reg.count - 1'b1;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) state_reg <= '0;
        else state_reg <= state_next;
    end

endmodule : csg_fifo
`default_nettype wire

// ---- design/csg_gate.sv ----
// Command state gate: prefix detection, down character counters, key repeat
// timer and the byte-wide configuration memory behind a Wishbone slave.
// Assumes characters of the first serial input arrive already on sys_clk.
//
// Functional notes
// (R1) Check every input character for entry prefix; code checks only outside command state
// (R2) Entry prefix from byte 03, default 02
// (R3) Exit command state on fixed character 03
// (R4) Sender brackets commands with prefix and exit
// (R5) Three counters, presets 40/43/46, count every character
// (R6) Counter at zero outputs its string pointer
// (R7) Token preamble/postamble pointers, postamble low 32
// (R8) Rate A delay 37, interval 25, 20ms units
// (R9) Rate B delay 25, interval 5, 20ms units
// (R10) Click and repeat settings byte 80, default 41
// (R11) Base layer byte 87, 128 or 129
// (R12) First layer pointer 88/89, zero means none
// (R13) Parallel direction byte 8C, default 00
// (R14) Serial 3-6 line format, default 42
// (R15) Serial 3-6 flow control, default 0C
// (R16) Byte 9A kept for display driver
// (R17) Prefix detection on first serial input
// (R18) Non-prefix characters outside command state pass as data
`timescale 1ns/10ps
`default_nettype none
module csg_gate #(
    parameter logic                      FIRMWARE_VARIANT_TWO = 1'b0,
    parameter logic [csg_pkg::TICK_W-1:0] UNIT_CYCLES =
        csg_pkg::TICK_W'(csg_pkg::REPEAT_UNIT_CYCLES)
) (
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [9:2]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic [31:0]              wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic                first_serial_input_valid,
    input  wire logic [7:0]          first_serial_input_data,
    output logic                     first_serial_input_ready,
    output logic                     out_valid,
    output csg_pkg::csg_char_t       out_char,
    input  wire logic                out_ready,
    output logic                     string_valid,
    output logic [1:0]               string_counter,
    output logic [15:0]              string_ptr,
    input  wire logic                string_ready,
    input  wire logic                key_held,
    input  wire logic                key_rate_b,
    output logic                     key_repeat,
    output csg_pkg::csg_cfg_t        cfg
);

    // ----------------
    // State
    // ----------------
    typedef struct packed {
        logic [255:0][7:0]          mem;
        logic                       cmd_mode;
        logic [2:0][7:0]            count;
        logic [2:0]                 pend;
        logic [1:0]                 str_idx;
        logic [15:0]                str_ptr;
        logic                       out_valid;
        csg_pkg::csg_char_t         out_char;
        logic                       ack;
        logic [31:0]                dat;
        logic [csg_pkg::TICK_W-1:0] tick_cnt;
        logic                       rep_active;
        logic [7:0]                 rep_cnt;
        logic                       key_held_d;
        logic                       key_repeat;
    } csg_state_t;

    csg_state_t         state_reg;
    csg_state_t         state_next;
    csg_state_t         state_init;
    logic               fifo_valid;
    logic               fifo_ready;
    csg_pkg::csg_char_t fifo_word;
    logic [7:0]         rx_char;
    logic [7:0]         wb_idx;
    logic               wb_req;
    logic               tick;

    function automatic logic [15:0] ptr_at(input logic [255:0][7:0] m,
                                           input logic [7:0] hi,
                                           input logic [7:0] lo);
        return {m[hi], m[lo]};
    endfunction : ptr_at

    function automatic logic [7:0] unit_load(input logic [7:0] v);
        return (v == 8'h00) ? 8'h01 : v;
    endfunction : unit_load

    // ----------------
    // Input buffer
    // ----------------
    csg_fifo #(
        .WIDTH ($bits(csg_pkg::csg_char_t)),
        .DEPTH (csg_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_valid  (first_serial_input_valid),
        .in_ready  (first_serial_input_ready),
        .in_data   ({1'b0, first_serial_input_data}),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_word)
    );

    assign rx_char    = fifo_word.ch;
    assign fifo_ready = !state_reg.out_valid && (state_reg.pend == 3'h0);
    assign wb_idx     = wb_adr_i[9:2];
    assign wb_req     = wb_cyc_i && wb_stb_i && !state_reg.ack;
    assign tick       = (state_reg.tick_cnt == UNIT_CYCLES - 1'b1);

    // ----------------
    // Reset image
    // ----------------
    always_comb begin
        state_init = '0;
        for (int i = 0; i < 256; i++) begin
            state_init.mem[i] = csg_pkg::csg_default(8'(i), FIRMWARE_VARIANT_TWO); // R2
        end
        for (int k = 0; k < 3; k++) begin
            state_init.count[k] = csg_pkg::RST_PRESET; // R5
        end
    end

    // ----------------
    // Next state
    // ----------------
    always_comb begin
        logic [7:0] dec;
        logic [2:0] hit;
        dec = 8'h00;
        hit = 3'h0;
        state_next = state_reg;
        state_next.key_repeat = 1'b0;

        // Output handshakes
        if (state_reg.out_valid && out_ready) begin
            state_next.out_valid = 1'b0;
        end
        if (state_reg.pend != 3'h0 && string_ready) begin
            state_next.pend = state_reg.pend & (state_reg.pend - 3'h1);
        end

        // Character handling
        if (fifo_valid && fifo_ready) begin // R17
            if (!state_reg.cmd_mode &&
                rx_char == state_reg.mem[csg_pkg::OFS_ENTRY_CHAR]) begin // R1 R2
                state_next.cmd_mode = 1'b1;
            end else if (state_reg.cmd_mode && rx_char == csg_pkg::EXIT_CHAR) begin // R3 R4
                state_next.cmd_mode = 1'b0;
            end else begin
                state_next.out_valid   = 1'b1;
                state_next.out_char.ch = rx_char;
                state_next.out_char.cmd = state_reg.cmd_mode; // R18
            end
            for (int k = 0; k < 3; k++) begin
                dec = state_reg.count[k] - 8'h01; // R5
                if (dec == 8'h00) begin
                    hit[k] = 1'b1; // R6
                    state_next.count[k] = state_reg.mem[csg_pkg::OFS_PRESET[k]];
                end else begin
                    state_next.count[k] = dec;
                end
            end
            state_next.pend = state_next.pend | hit;
        end

        // Pointer of the lowest pending counter string
        state_next.str_idx = 2'h0;
        state_next.str_ptr = 16'h0000;
        for (int k = 2; k >= 0; k--) begin
            if (state_next.pend[k]) begin
                state_next.str_idx = 2'(k);
                state_next.str_ptr = ptr_at(state_reg.mem, csg_pkg::OFS_STR_HI[k],
                                            csg_pkg::OFS_STR_LO[k]); // R6
            end
        end

        // Key repeat timing
        state_next.tick_cnt = tick ? '0 : state_reg.tick_cnt + 1'b1;
        state_next.key_held_d = key_held;
        if (!key_held) begin
            state_next.rep_active = 1'b0;
        end else if (!state_reg.key_held_d) begin
            state_next.rep_active = 1'b1;
            state_next.rep_cnt = unit_load(key_rate_b ?
                state_reg.mem[csg_pkg::OFS_RB_DELAY] :
                state_reg.mem[csg_pkg::OFS_RA_DELAY]); // R8 R9
        end else if (state_reg.rep_active && tick) begin
            if (state_reg.rep_cnt == 8'h01) begin
                state_next.key_repeat = 1'b1;
                state_next.rep_cnt = unit_load(key_rate_b ?
                    state_reg.mem[csg_pkg::OFS_RB_INTERVAL] :
                    state_reg.mem[csg_pkg::OFS_RA_INTERVAL]); // R8 R9
            end else begin
                state_next.rep_cnt = state_reg.rep_cnt - 8'h01;
            end
        end

        // Wishbone slave
        state_next.ack = wb_req;
        state_next.dat = 32'h0000_0000;
        if (wb_req && !wb_we_i) begin
            if (wb_idx == csg_pkg::OFS_STATUS) begin
                state_next.dat[csg_pkg::STAT_CMD_BIT] = state_reg.cmd_mode;
                state_next.dat[csg_pkg::STAT_PEND_LSB +: 3] = state_reg.pend;
            end else if (wb_idx == csg_pkg::OFS_COUNT[0]) begin
                state_next.dat[7:0] = state_reg.count[0];
            end else if (wb_idx == csg_pkg::OFS_COUNT[1]) begin
                state_next.dat[7:0] = state_reg.count[1];
            end else if (wb_idx == csg_pkg::OFS_COUNT[2]) begin
                state_next.dat[7:0] = state_reg.count[2];
            end else if (csg_pkg::csg_is_cfg(wb_idx)) begin
                state_next.dat[7:0] = state_reg.mem[wb_idx];
            end
        end
        if (wb_req && wb_we_i && wb_sel_i[0] && csg_pkg::csg_is_cfg(wb_idx)) begin
            state_next.mem[wb_idx] = wb_dat_i[7:0];
            for (int k = 0; k < 3; k++) begin
                if (wb_idx == csg_pkg::OFS_PRESET[k]) begin
                    state_next.count[k] = wb_dat_i[7:0]; // R5
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) state_reg <= state_init;
        else state_reg <= state_next;
    end

    // ----------------
    // Outputs
    // ----------------
    assign wb_dat_o       = state_reg.dat;
    assign wb_ack_o       = state_reg.ack;
    assign out_valid      = state_reg.out_valid;
    assign out_char       = state_reg.out_char;
    assign string_valid   = (state_reg.pend != 3'h0);
    assign string_counter = state_reg.str_idx;
    assign string_ptr     = state_reg.str_ptr;
    assign key_repeat     = state_reg.key_repeat;

    always_comb begin
        cfg = '0;
        cfg.entry_char     = state_reg.mem[csg_pkg::OFS_ENTRY_CHAR];
        cfg.token_pre_ptr  = ptr_at(state_reg.mem, csg_pkg::OFS_PRE_PTR_HI,
                                    csg_pkg::OFS_PRE_PTR_LO); // R7
        cfg.token_post_ptr = ptr_at(state_reg.mem, csg_pkg::OFS_POST_PTR_HI,
                                    csg_pkg::OFS_POST_PTR_LO); // R7
        cfg.click_repeat   = state_reg.mem[csg_pkg::OFS_CLICK_RPT]; // R10
        cfg.base_layer     = state_reg.mem[csg_pkg::OFS_BASE_LAYER]; // R11
        cfg.first_layer_ptr = ptr_at(state_reg.mem, csg_pkg::OFS_LAYER_HI,
                                     csg_pkg::OFS_LAYER_LO);
        cfg.first_layer_present = (cfg.first_layer_ptr != 16'h0000); // R12
        cfg.parallel_dir   = state_reg.mem[csg_pkg::OFS_PAR_DIR]; // R13
        for (int i = 0; i < 4; i++) begin
            cfg.serial_fmt[i]  = state_reg.mem[csg_pkg::OFS_SER_FMT[i]]; // R14
            cfg.serial_flow[i] = state_reg.mem[csg_pkg::OFS_SER_FLOW[i]]; // R15
        end
        cfg.display_private = state_reg.mem[csg_pkg::OFS_DISP_PRIV]; // R16
    end

endmodule : csg_gate
`default_nettype wire

// ---- testbench/csg_host_model.sv ----
// Host that sends queued characters on the first serial input.
// Holds each character until the gate takes it.
`timescale 1ns/10ps
`default_nettype none
module csg_host_model (
    input  wire logic      sys_clk,
    input  wire logic      sys_rst,
    input  wire logic      first_serial_input_ready,
    output var logic       first_serial_input_valid,
    output var logic [7:0] first_serial_input_data
);
    logic [7:0] q[$];
    initial begin
        first_serial_input_valid = 1'b0;
        first_serial_input_data  = 8'h00;
    end
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            first_serial_input_valid <= 1'b0;
        end else begin
            if (first_serial_input_valid && first_serial_input_ready) void'(q.pop_front());
            first_serial_input_valid <= (q.size() != 0);
            first_serial_input_data  <= (q.size() != 0) ? q[0] : ~first_serial_input_data;
        end
    end
endmodule : csg_host_model
`default_nettype wire

// ---- testbench/csg_gate_checker.sv ----
// Port assertions for the command state gate.
// Bound to every csg_gate instance.
`timescale 1ns/10ps
`default_nettype none
module csg_gate_checker (
    input wire logic               sys_clk,
    input wire logic               sys_rst,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_ack_o,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               out_valid,
    input wire logic               out_ready,
    input wire csg_pkg::csg_char_t out_char,
    input wire logic               string_valid,
    input wire logic               string_ready,
    input wire logic [15:0]        string_ptr,
    input wire logic               key_repeat,
    input wire csg_pkg::csg_cfg_t  cfg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_ack_drop; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack too long");
    property p_rd_zero; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read upper bits set");
    property p_out_hold; out_valid && !out_ready |=> out_valid && $stable(out_char); endproperty
    a_out_hold: assert property (p_out_hold) else $error("char dropped");
    property p_prefix; out_valid && !out_char.cmd |-> out_char.ch != cfg.entry_char; endproperty
    a_prefix: assert property (p_prefix) else $error("prefix passed as data");
    property p_exit; out_valid && out_char.cmd |-> out_char.ch != 8'h03; endproperty
    a_exit: assert property (p_exit) else $error("exit char sent to interpreter");
    property p_str_hold; string_valid && !string_ready |=> string_valid && $stable(string_ptr);
    endproperty
    a_str_hold: assert property (p_str_hold) else $error("string dropped");
    property p_dflt; $fell(sys_rst) |-> cfg.entry_char == 8'h02 && cfg.token_post_ptr == 16'h0032;
    endproperty
    a_dflt: assert property (p_dflt) else $error("bad defaults");
    property p_layer; cfg.first_layer_present == (cfg.first_layer_ptr != 16'h0000); endproperty
    a_layer: assert property (p_layer) else $error("layer flag wrong");
    property p_rpt; key_repeat |=> !key_repeat [*2]; endproperty
    a_rpt: assert property (p_rpt) else $error("repeat pulse too long");
endmodule : csg_gate_checker
bind csg_gate csg_gate_checker i_chk (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .wb_dat_o, .out_valid, .out_ready, .out_char, .string_valid, .string_ready, .string_ptr,
    .key_repeat, .cfg);
`default_nettype wire

// ---- testbench/tb_command_state_gate_config.sv ----
// Self-checking bench for the command state gate.
// Wishbone and sink driven by hand; a host model sends characters.
`timescale 1ns/10ps
`default_nettype none
module tb_command_state_gate_config;
    logic sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, out_valid, out_ready;
    logic string_valid, string_ready, key_held, key_rate_b, key_repeat;
    logic first_serial_input_valid, first_serial_input_ready;
    logic [7:0] wb_adr_i, first_serial_input_data;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [1:0] string_counter;
    logic [15:0] string_ptr, ptr_two;
    csg_pkg::csg_char_t out_char;
    csg_pkg::csg_cfg_t cfg;
    csg_pkg::csg_char_t got[$];
    int num_errors = 0, checks = 0, cycles = 0;
    int n_str[3] = '{0, 0, 0};
    localparam logic [7:0] dof [25] = '{8'h03, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41,
        8'h43, 8'h46, 8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h87, 8'h88, 8'h89, 8'h8c, 8'h8e,
        8'h8f, 8'h91, 8'h92, 8'h97, 8'h98, 8'h49};
    localparam logic [7:0] dvl [25] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h32, 8'h01, 8'h00,
        8'h01, 8'h01, 8'h41, 8'h25, 8'h19, 8'h19, 8'h05, 8'h80, 8'h00, 8'h00, 8'h00, 8'h42,
        8'h0c, 8'h42, 8'h0c, 8'h42, 8'h0c, 8'h00};
    localparam logic [7:0] tx [12] = '{8'h41, 8'h02, 8'h42, 8'h02, 8'h03, 8'h03, 8'h43,
        8'h44, 8'h45, 8'h46, 8'h47, 8'h48};
    localparam logic [8:0] oex [10] = '{9'h041, 9'h142, 9'h102, 9'h003, 9'h043, 9'h044,
        9'h045, 9'h046, 9'h047, 9'h048};

    csg_gate #(.UNIT_CYCLES(20'h0000a)) i_dut (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .first_serial_input_valid, .first_serial_input_data, .first_serial_input_ready,
        .out_valid, .out_char, .out_ready, .string_valid, .string_counter, .string_ptr,
        .string_ready, .key_held, .key_rate_b, .key_repeat, .cfg);
    csg_host_model i_host (.sys_clk, .sys_rst, .first_serial_input_ready,
        .first_serial_input_valid, .first_serial_input_data);

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            test_done();
        end
        if (out_valid && out_ready) got.push_back(out_char);
        if (string_valid && string_ready) begin
            n_str[string_counter]++;
            if (string_counter == 2'h1) ptr_two = string_ptr;
        end
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] r);
        int n;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, 24'h000000, d};
        n = 0;
        do begin @(posedge sys_clk); n++; end while (wb_ack_o !== 1'b1 && n < 50);
        r = wb_dat_o[7:0];
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        chk("wb ack", 16'(n), 16'h0002);
    endtask : wb

    task automatic t_regs;
        logic [7:0] r;
        for (int i = 0; i < 25; i++) begin
            wb(1'b0, dof[i], 8'h00, r);
            chk("default", 16'(r), 16'(dvl[i]));
        end
        wb(1'b1, 8'h49, 8'ha5, r);
        wb(1'b0, 8'h49, 8'h00, r);
        chk("unmapped", 16'(r), 16'h0000);
        wb(1'b1, 8'h9a, 8'h5a, r);
        wb(1'b0, 8'h9a, 8'h00, r);
        chk("private", 16'(r), 16'h005a);
        wb(1'b1, 8'h89, 8'h01, r);
        wb(1'b1, 8'h8c, 8'h07, r);
        @(posedge sys_clk);
        chk("layer", {cfg.first_layer_ptr[14:0], cfg.first_layer_present}, 16'h0003);
        chk("pdir", 16'(cfg.parallel_dir), 16'h0007);
        wb(1'b1, 8'h89, 8'h00, r);
        @(posedge sys_clk);
        chk("none", 16'(cfg.first_layer_present), 16'h0000);
        wb(1'b1, 8'h43, 8'h05, r);
        wb(1'b1, 8'h46, 8'h03, r);
        wb(1'b1, 8'h44, 8'h12, r);
        wb(1'b1, 8'h45, 8'h34, r);
        $display("test regs done");
    endtask : t_regs

    task automatic t_stream;
        foreach (tx[i]) i_host.q.push_back(tx[i]);
        repeat (40) @(posedge sys_clk);
        chk("in_ready", 16'(first_serial_input_ready), 16'h0000);
        {out_ready, string_ready} <= 2'h3;
        repeat (120) @(posedge sys_clk);
        chk("n_out", 16'(got.size()), 16'h000a);
        for (int i = 0; i < 10; i++) chk("out_char", 16'(got[i]), 16'(oex[i]));
        chk("str one", 16'(n_str[0]), 16'h000c);
        chk("str two", 16'(n_str[1]), 16'h0002);
        chk("str three", 16'(n_str[2]), 16'h0004);
        chk("ptr two", ptr_two, 16'h1234);
        $display("test stream done");
    endtask : t_stream

    task automatic t_repeat(input logic b, input int dly, input int ivl);
        int t;
        @(posedge sys_clk);
        {key_rate_b, key_held} <= {b, 1'b1};
        t = 0;
        do begin @(posedge sys_clk); t++; end while (key_repeat !== 1'b1 && t < 1000);
        chk("delay", 16'(t + 11 >= dly * 10 && t <= dly * 10 + 11), 16'h0001);
        t = 0;
        do begin @(posedge sys_clk); t++; end while (key_repeat !== 1'b1 && t < 1000);
        chk("interval", 16'(t + 11 >= ivl * 10 && t <= ivl * 10 + 11), 16'h0001);
        key_held <= 1'b0;
        $display("test repeat done");
    endtask : t_repeat

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, out_ready, string_ready, key_held, key_rate_b} = '0;
        {wb_adr_i, wb_sel_i, wb_dat_i, ptr_two, sys_rst} = {8'h00, 4'h1, 32'h0, 16'h0, 1'b1};
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_stream();
        t_repeat(1'b0, 37, 25);
        t_repeat(1'b1, 25, 5);
        test_done();
    end
endmodule : tb_command_state_gate_config
`default_nettype wire
